// ---- dv/incdec_core_properties.sv ----
// Purpose: Bus and interrupt-view timing checks on incdec_core
// Assumes: Single clock, synchronous active-low reset
// Notes:   Bound to the core from the foot of this file
`timescale 1ns/1ps
`default_nettype none
module incdec_core_properties
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Write channels
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Read channels
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Interrupt view
    input wire logic        irq_take_q
);
    // ==========================================
    // Properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready not a pulse");
    a_arready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready not a pulse");
    a_awready_gated: assert property (s_axi_awready |-> s_axi_awvalid)
        else $error("awready without request");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    a_take_on_cmd: assert property (
        irq_take_q |-> s_axi_bvalid ##1 !irq_take_q)
        else $error("take pulse outside a command");
    a_reset_quiet: assert property ($rose(aresetn)
        |-> !s_axi_bvalid && !s_axi_rvalid && !irq_take_q)
        else $error("outputs busy after reset");
endmodule // incdec_core_properties

bind incdec_core incdec_core_properties chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq_take_q(irq_take_q));
`default_nettype wire

// ---- dv/incdec_core_tb.sv ----
// Purpose: Self-checking bench for incdec_core
// Assumes: Register access over AXI4-Lite only
// Notes:   Each arith case loads operand and status, each exec case pc and status, then issues a command
`timescale 1ns/1ps
`default_nettype none
`include "incdec_consts.vh"
module incdec_core_tb;
    // ==========================================
    // Signals
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, slow = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, got;
    logic [1:0]  bresp, rresp, gresp;
    logic        awready, wready, bvalid, arready, rvalid, irq_take_q;
    int          bad_count = 0, checks_done = 0, takes = 0;

    // Clock and pulse counter
    always #50 aclk = ~aclk;
    always @(posedge aclk) if (irq_take_q === 1'b1) takes <= takes + 1;

    incdec_core dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq_take_q(irq_take_q));

    // ==========================================
    // Bus tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic done;
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= !slow;
            done = 1'b0;
            while (!done)
            begin
                @(posedge aclk);
                if (awvalid && awready) awvalid <= 1'b0;
                if (wvalid && wready) wvalid <= 1'b0;
                if (bvalid === 1'b1 && bready)
                begin
                    gresp = bresp;
                    bready <= 1'b0;
                    done = 1'b1;
                end
                else if (bvalid === 1'b1)
                    bready <= 1'b1;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a);
        logic done;
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= !slow;
            done = 1'b0;
            while (!done)
            begin
                @(posedge aclk);
                if (arvalid && arready) arvalid <= 1'b0;
                if (rvalid === 1'b1 && rready)
                begin
                    got = rdata;
                    gresp = rresp;
                    rready <= 1'b0;
                    done = 1'b1;
                end
                else if (rvalid === 1'b1)
                    rready <= 1'b1;
            end
        end
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        begin
            checks_done = checks_done + 1;
            if (s !== e)
            begin
                bad_count = bad_count + 1;
                $display("MISMATCH %0t got %h want %h", $time, s, e);
            end
        end
    endtask

    // Arithmetic case: f is {n, z, c, v}; flags preset to the inverse
    task automatic arith(input logic [3:0] o, input logic b,
        input logic [15:0] v, input logic [15:0] r, input logic [3:0] f);
        logic [15:0] fl;
        begin
            fl = {7'h0, f[0], 5'h0, f[3:1]};
            wr(`REG_OPERAND, {16'h0, v});
            wr(`REG_STATUS, {16'h0, 16'h0038 | (fl ^ 16'h0107)});
            wr(`REG_CMD, {27'h0, b, o});
            rd(`REG_OPERAND);
            chk(got, {16'h0, r});
            rd(`REG_RESULT);
            chk(got, {16'h0, r});
            rd(`REG_STATUS);
            chk(got, {16'h0, 16'h0038 | fl});
        end
    endtask

    // Control case: status s in, pc from 0100, expect pc p and status e
    task automatic exec(input logic [3:0] o, input logic [15:0] s,
        input logic [9:0] f, input logic [15:0] p, input logic [15:0] e);
        begin
            wr(`REG_PC, 32'h0000_0100);
            wr(`REG_STATUS, {16'h0, s});
            wr(`REG_CMD, {14'h0, f, 4'h0, o});
            rd(`REG_PC);
            chk(got, {16'h0, p});
            rd(`REG_STATUS);
            chk(got, {16'h0, e});
        end
    endtask

    task automatic wrap_up;
        begin
            if (bad_count == 0 && checks_done > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    // ==========================================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`REG_STATUS);
        chk(got, {16'h0, `SW_RESET});
        rd(`REG_PC);
        chk(got, {16'h0, `PC_RESET});
        arith(`OP_DECR1, 1'b0, 16'h0001, 16'h0000, 4'b0110);
        arith(`OP_DECR1, 1'b0, 16'h0000, 16'hffff, 4'b1000);
        arith(`OP_DECR1, 1'b0, 16'h8000, 16'h7fff, 4'b0011);
        arith(`OP_DECR1, 1'b1, 16'h1280, 16'h007f, 4'b0011);
        arith(`OP_DECR2, 1'b0, 16'h0002, 16'h0000, 4'b0110);
        arith(`OP_DECR2, 1'b0, 16'h0001, 16'hffff, 4'b1000);
        arith(`OP_DECR2, 1'b0, 16'h8001, 16'h7fff, 4'b0011);
        arith(`OP_DECR2, 1'b1, 16'h3480, 16'h007e, 4'b0011);
        arith(`OP_INCR1, 1'b0, 16'hffff, 16'h0000, 4'b0110);
        arith(`OP_INCR1, 1'b0, 16'h7fff, 16'h8000, 4'b1001);
        arith(`OP_INCR1, 1'b1, 16'h56ff, 16'h0000, 4'b0110);
        arith(`OP_INCR2, 1'b0, 16'hfffe, 16'h0000, 4'b0110);
        arith(`OP_INCR2, 1'b0, 16'hffff, 16'h0001, 4'b0010);
        arith(`OP_INCR2, 1'b0, 16'h7ffe, 16'h8000, 4'b1001);
        arith(`OP_INCR2, 1'b1, 16'hab7f, 16'h0081, 4'b1001);
        arith(`OP_INVERT, 1'b0, 16'h0000, 16'hffff, 4'b1010);
        arith(`OP_INVERT, 1'b0, 16'hffff, 16'h0000, 4'b0101);
        arith(`OP_INVERT, 1'b1, 16'hcd80, 16'h007f, 4'b0011);
        exec(`OP_IRQ_OFF, 16'h013f, 10'h000, 16'h0100, 16'h0137);
        exec(`OP_IRQ_ON, 16'h0137, 10'h000, 16'h0100, 16'h013f);
        exec(`OP_JMP_CARRY, 16'h0001, 10'h3ff, 16'h00fe, 16'h0001);
        exec(`OP_JMP_CARRY, 16'h013e, 10'h3ff, 16'h0100, 16'h013e);
        exec(`OP_JMP_ZERO, 16'h0002, 10'h1ff, 16'h04fe, 16'h0002);
        exec(`OP_JMP_ZERO, 16'h0002, 10'h200, 16'hfd00, 16'h0002);
        exec(`OP_JMP_ZERO, 16'h013d, 10'h001, 16'h0100, 16'h013d);
        // Unmapped place: refused, reads as zero; ready raised late
        slow = 1'b1;
        wr(8'h40, 32'h0000_1234);
        chk({30'h0, gresp}, {30'h0, `RESP_SLVERR});
        rd(8'h40);
        chk({30'h0, gresp}, {30'h0, `RESP_SLVERR});
        chk(got, 32'h0);
        slow = 1'b0;
        // Pending request across an enable: one instruction runs first
        wr(`REG_IRQ, 32'h0000_0001);
        exec(`OP_IRQ_ON, 16'h0000, 10'h000, 16'h0100, 16'h0008);
        wr(`REG_CMD, 32'h0);
        @(posedge aclk);
        chk(takes, 32'd0);
        wr(`REG_CMD, 32'h0);
        @(posedge aclk);
        chk(takes, 32'd1);
        // Disable one ahead: a take may land on the disable itself only
        wr(`REG_CMD, {28'h0, `OP_IRQ_OFF});
        wr(`REG_CMD, 32'h0);
        wr(`REG_CMD, 32'h0);
        @(posedge aclk);
        chk(takes, 32'd2);
        rd(`REG_STATUS);
        chk(got, 32'h0);
        wrap_up;
    end

    // Watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge aclk);
        bad_count = bad_count + 1;
        wrap_up;
    end
endmodule // incdec_core_tb
`default_nettype wire

// ---- rtl/incdec_consts.vh ----
// Summary of operation
// - Single decrement writes destination minus one
// - Zero if was 1; carry clear if 0
// - Overflow only from most negative value
// - Double decrement writes destination minus two
// - Zero if was 2; carry clear 0/1
// - Overflow for 8001h/8000h or 81h/80h
// - Negative flag follows result sign bit
// - Disable clears only interrupt enable bit
// - Enable sets only interrupt enable bit
// - Instruction after enable runs before interrupt
// - Arithmetic ops keep mode bits untouched
// - Increment adds one; zero if all ones
// - Increment overflow from largest positive value
// - Double increment adds two; carry, zero
// - Double increment overflow for 7FFE/7FFF
// - Invert writes bitwise complement
// - Invert carry is not zero; V negative
// - Jump on carry adds twice offset
// - Jump on zero adds twice offset
// - Jumps and irq ops keep flags
//
// Purpose: Constants for the increment/decrement/invert datapath
// Assumes: Status word bit layout C=0 Z=1 N=2 irq enable=3 V=8
// Notes:   Register offsets of the AXI4-Lite slave
`ifndef INCDEC_CONSTS_VH
`define INCDEC_CONSTS_VH
// Status word bit positions
`define SW_C          0
`define SW_Z          1
`define SW_N          2
`define SW_IRQ_EN     3
`define SW_CORE_OFF   4
`define SW_OSC_OFF    5
`define SW_V          8
`define SW_IRQ_EN_MASK 16'h0008
`define SW_RESET      16'h0000
`define PC_RESET      16'h0000
// Operation codes
`define OP_NONE       4'h0
`define OP_DECR1      4'h1
`define OP_DECR2      4'h2
`define OP_INCR1      4'h3
`define OP_INCR2      4'h4
`define OP_INVERT     4'h5
`define OP_IRQ_OFF    4'h6
`define OP_IRQ_ON     4'h7
`define OP_JMP_CARRY  4'h8
`define OP_JMP_ZERO   4'h9
// Register byte offsets
`define REG_CMD       8'h00
`define REG_OPERAND   8'h04
`define REG_RESULT    8'h08
`define REG_STATUS    8'h0c
`define REG_PC        8'h10
`define REG_IRQ       8'h14
// Command register fields
`define CMD_BYTE_BIT  4
`define CMD_OFS_LSB   8
`define CMD_OFS_MSB   17
// Interrupt register fields
`define IRQ_PEND_BIT  0
`define IRQ_TAKE_BIT  1
`define IRQ_HOLD_BIT  2
// AXI responses
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// ---- rtl/incdec_core.v ----
// Purpose: Increment, decrement, invert, irq gate and conditional jumps
// Assumes: AXI4-Lite master, one write and one read at a time
// Notes:   Writing the command register executes one instruction
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "incdec_consts.vh"
module incdec_core
(
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // Write address channel
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // Write data channel
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // Write response channel
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // Read address channel
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // Read data channel
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Interrupt acceptance view
    output reg         irq_take_q
);

    // =========================================================
    // Datapath state
    // =========================================================
    reg [15:0] operand_q;
    reg [15:0] result_q;
    reg [15:0] status_word_q;
    reg [15:0] pc_q;
    reg        irq_pend_q;
    reg        irq_hold_q;
    reg [7:0]  awaddr_q;
    reg        aw_have_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;
    reg        w_have_q;

    // Merge a 16-bit value under byte strobes
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0]  strb;
        begin
            merge16 = old;
            if (strb[0])
                merge16[7:0] = data[7:0];
            if (strb[1])
                merge16[15:8] = data[15:8];
        end
    endfunction

    // Sign bit at the operand size
    function msb_of;
        input [15:0] v;
        input        is_byte;
        begin
            msb_of = is_byte ? v[7] : v[15];
        end
    endfunction

    // Value equality at the operand size
    function size_eq;
        input [15:0] v;
        input [15:0] k;
        input        is_byte;
        begin
            size_eq = is_byte ? (v[7:0] == k[7:0]) : (v == k);
        end
    endfunction

    // =========================================================
    // Instruction execution (combinational)
    // =========================================================
    wire        wr_fire  = aw_have_q && w_have_q && !s_axi_bvalid;
    wire        cmd_go   = wr_fire && (awaddr_q == `REG_CMD);
    wire [3:0]  op       = wdata_q[3:0];
    wire        bsz      = wdata_q[`CMD_BYTE_BIT];
    wire [9:0]  ofs      = wdata_q[`CMD_OFS_MSB:`CMD_OFS_LSB];
    wire [15:0] pc_jump  = pc_q + {{5{ofs[9]}}, ofs, 1'b0};
    wire [15:0] d        = operand_q;

    reg [15:0] res;
    reg        wr_res;
    reg        flags_upd;
    reg        f_n;
    reg        f_z;
    reg        f_c;
    reg        f_v;
    reg [15:0] sw_d;
    reg [15:0] pc_d;

    // Operation decode and flag rules
    always @*
    begin
        res = 16'h0000;
        wr_res = 1'b0;
        flags_upd = 1'b0;
        f_c = 1'b0;
        f_z = 1'b0;
        f_v = 1'b0;
        sw_d = status_word_q;
        pc_d = pc_q;
        case (op)
            `OP_DECR1:
            begin
                res = d - 16'h0001;
                wr_res = 1'b1;
                flags_upd = 1'b1;
                f_z = size_eq(d, 16'h0001, bsz);
                f_c = !size_eq(d, 16'h0000, bsz);
                f_v = size_eq(d, bsz ? 16'h0080 : 16'h8000, bsz);
            end
            `OP_DECR2:
            begin
                res = d - 16'h0002;
                wr_res = 1'b1;
                flags_upd = 1'b1;
                f_z = size_eq(d, 16'h0002, bsz);
                f_c = !(size_eq(d, 16'h0000, bsz) ||
                        size_eq(d, 16'h0001, bsz));
                f_v = size_eq(d, bsz ? 16'h0080 : 16'h8000, bsz) ||
                      size_eq(d, bsz ? 16'h0081 : 16'h8001, bsz);
            end
            `OP_INCR1:
            begin
                res = d + 16'h0001;
                wr_res = 1'b1;
                flags_upd = 1'b1;
                f_z = size_eq(d, 16'hffff, bsz);
                f_c = f_z;
                f_v = size_eq(d, bsz ? 16'h007f : 16'h7fff, bsz);
            end
            `OP_INCR2:
            begin
                res = d + 16'h0002;
                wr_res = 1'b1;
                flags_upd = 1'b1;
                f_z = size_eq(d, 16'hfffe, bsz);
                f_c = f_z || size_eq(d, 16'hffff, bsz);
                f_v = size_eq(d, bsz ? 16'h007e : 16'h7ffe, bsz) ||
                      size_eq(d, bsz ? 16'h007f : 16'h7fff, bsz);
            end
            `OP_INVERT:
            begin
                res = d ^ 16'hffff;
                wr_res = 1'b1;
                flags_upd = 1'b1;
                f_z = size_eq(res, 16'h0000, bsz);
                f_c = !f_z;
                f_v = msb_of(d, bsz);
            end
            `OP_IRQ_OFF:
                sw_d = status_word_q & ~`SW_IRQ_EN_MASK;
            `OP_IRQ_ON:
                sw_d = status_word_q | `SW_IRQ_EN_MASK;
            `OP_JMP_CARRY:
                if (status_word_q[`SW_C])
                    pc_d = pc_jump;
            `OP_JMP_ZERO:
                if (status_word_q[`SW_Z])
                    pc_d = pc_jump;
            default:
                sw_d = status_word_q;
        endcase
        // Byte results clear the high byte
        if (bsz)
            res = {8'h00, res[7:0]};
        f_n = msb_of(res, bsz);
        // Only the four flags change; mode bits kept
        if (flags_upd)
        begin
            sw_d[`SW_N] = f_n;
            sw_d[`SW_Z] = f_z;
            sw_d[`SW_C] = f_c;
            sw_d[`SW_V] = f_v;
        end
    end

    // =========================================================
    // Datapath registers and interrupt gate
    // =========================================================
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            operand_q <= 16'h0000;
            result_q <= 16'h0000;
            status_word_q <= `SW_RESET;
            pc_q <= `PC_RESET;
        end
        else
        begin
            if (cmd_go)
            begin
                if (wr_res)
                begin
                    result_q <= res;
                    operand_q <= res;
                end
                status_word_q <= sw_d;
                pc_q <= pc_d;
            end
            else if (wr_fire && awaddr_q == `REG_OPERAND)
                operand_q <= merge16(operand_q, wdata_q, wstrb_q);
            else if (wr_fire && awaddr_q == `REG_STATUS)
                status_word_q <= merge16(status_word_q, wdata_q, wstrb_q);
            else if (wr_fire && awaddr_q == `REG_PC)
                pc_q <= merge16(pc_q, wdata_q, wstrb_q);
        end
    end

    // Interrupt gate: hold after enable, take at boundary
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_hold_q <= 1'b0;
            irq_take_q <= 1'b0;
        end
        else if (cmd_go)
        begin
            // Enable shields the following instruction
            irq_hold_q <= (op == `OP_IRQ_ON);
            // Acceptance decided at instruction boundary
            irq_take_q <= irq_pend_q && status_word_q[`SW_IRQ_EN] &&
                          !irq_hold_q && (op != `OP_IRQ_ON);
        end
        else
            irq_take_q <= 1'b0;
    end

    // Pending request flag, written by software
    always @(posedge aclk)
    begin
        if (!aresetn)
            irq_pend_q <= 1'b0;
        else if (wr_fire && awaddr_q == `REG_IRQ && wstrb_q[0])
            irq_pend_q <= wdata_q[`IRQ_PEND_BIT];
    end

    // =========================================================
    // AXI4-Lite write path
    // =========================================================
    wire wr_ok = (awaddr_q == `REG_CMD) || (awaddr_q == `REG_OPERAND) ||
                 (awaddr_q == `REG_STATUS) || (awaddr_q == `REG_PC) ||
                 (awaddr_q == `REG_IRQ);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end
        else
        begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_q <= s_axi_awaddr & 8'hfc;
                aw_have_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
            end
            if (wr_fire)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // =========================================================
    // AXI4-Lite read path
    // =========================================================
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready &&
                             s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                case (s_axi_araddr & 8'hfc)
                    `REG_CMD:     s_axi_rdata <= 32'h00000000;
                    `REG_OPERAND: s_axi_rdata <= {16'h0000, operand_q};
                    `REG_RESULT:  s_axi_rdata <= {16'h0000, result_q};
                    `REG_STATUS:  s_axi_rdata <= {16'h0000, status_word_q};
                    `REG_PC:      s_axi_rdata <= {16'h0000, pc_q};
                    `REG_IRQ:     s_axi_rdata <= {29'h0, irq_hold_q,
                                                  irq_take_q, irq_pend_q};
                    default:
                    begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule // incdec_core
`default_nettype wire
